//--- core/dtc_top.sv
// dual 16-bit timer/counter with joined 32-bit and rtc modes
`timescale 1ns/100ps
`include "dtc_params.svh"
// Behaviour
// - two independent 16-bit timer or counter halves
// - halves join into one 32-bit counter
// - one-shot stops at zero
// - periodic reloads at zero and continues
// - rtc only in joined mode
// - rtc divides 32 KHz to one second
// - capture and pwm only in paired mode
// - capture measures time or counts events
// - capture edge rising, falling or both
// - pwm turns capture pin into output
// - capture event and match interrupt sources
// - timeout and rtc match interrupt sources
// - configuring disables and leaves disabled
// - each half picks its own mode
// - invert makes pwm output active low
// - stall halts timer counting in debug mode; rtc and edge counting run on
// - trigger control gates output trigger
// - per-half enable gates counting
// - load write while running loads immediately
// - prescaler works only in paired mode
// - match sets count interrupt and pwm duty
// - mask gates sources; raw and masked readable
module dtc_top (
  input  wire logic        clk_i,      // 50 MHz clock
  input  wire logic        srst_i,     // sync reset, high
  input  wire logic [7:0]  addr_i,     // register byte address
  input  wire logic [31:0] wdata_i,    // write data
  input  wire logic        wr_i,       // write strobe
  input  wire logic        rd_i,       // read strobe
  output logic      [31:0] rdata_o,    // read data, cycle after rd_i
  input  wire logic        dbg_halt_i, // processor in debug mode
  input  wire logic        rtc_clk_i,  // 32 KHz clock, sampled
  input  wire logic        cap_a_i,    // first half capture pin in
  output logic             cap_a_o,    // first half pwm out
  output logic             cap_a_oe_o, // first half pin drive
  input  wire logic        cap_b_i,    // second half capture pin in
  output logic             cap_b_o,    // second half pwm out
  output logic             cap_b_oe_o, // second half pin drive
  output logic             trig_a_o,   // first half trigger pulse
  output logic             trig_b_o,   // second half trigger pulse
  output logic             irq_o       // masked interrupt
);
  dtc_pkg::dtc_cfg_e  cfg_q;
  dtc_pkg::dtc_half_e mode_a_q, mode_b_q;
  logic [31:0] ctrl_q, imr_q, ris_q, load_q, match_q, cnt_q;
  logic [7:0]  pre_a_q, pre_b_q, psc_a_q, psc_b_q;
  logic [14:0] rtc_div_q;
  logic        rtc_s_q, cap_a_s_q, cap_b_s_q;
  logic [31:0] set_w;
  logic        pair_w, tick_a_w, tick_b_w, tick_32_w, rtc_sec_w;
  logic        ev_a_w, ev_b_w;
  logic        wr_cfg_w, wr_ctrl_w, wr_la_w, wr_lb_w;

  // edge select: 0 rising, 1 falling, 2/3 both
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic cur, input logic prev);
    case (sel)
      2'h0:    edge_hit = cur & ~prev;
      2'h1:    edge_hit = ~cur & prev;
      default: edge_hit = cur ^ prev;
    endcase
  endfunction : edge_hit

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_i && (addr_i == ofs);
  endfunction : wr_at

  assign pair_w    = (cfg_q == dtc_pkg::DTC_PAIR);
  assign wr_cfg_w  = wr_at(`DTC_CFG_OFS) | wr_at(`DTC_MODE_A_OFS)
                   | wr_at(`DTC_MODE_B_OFS);
  assign wr_ctrl_w = wr_at(`DTC_CTRL_OFS);
  assign wr_la_w   = wr_at(`DTC_LOAD_A_OFS);
  assign wr_lb_w   = wr_at(`DTC_LOAD_B_OFS);

  // configuration registers; a config write clears both enables below
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q    <= dtc_pkg::DTC_PAIR;
      mode_a_q <= dtc_pkg::DTC_H_OS;
      mode_b_q <= dtc_pkg::DTC_H_OS;
    end else begin
      if (wr_at(`DTC_CFG_OFS))
        cfg_q <= dtc_pkg::dtc_cfg_e'(wdata_i[1:0]);
      if (wr_at(`DTC_MODE_A_OFS) && wdata_i[2:0] <= 3'h4)
        mode_a_q <= dtc_pkg::dtc_half_e'(wdata_i[2:0]);
      if (wr_at(`DTC_MODE_B_OFS) && wdata_i[2:0] <= 3'h4)
        mode_b_q <= dtc_pkg::dtc_half_e'(wdata_i[2:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i)
      ctrl_q <= 32'h00000000;
    else if (wr_cfg_w)
      ctrl_q <= ctrl_q & ~(32'h1 << `DTC_CTRL_EN_A
                         | 32'h1 << `DTC_CTRL_EN_B);
    else if (wr_ctrl_w)
      ctrl_q <= wdata_i & `DTC_CTRL_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      imr_q   <= 32'h00000000;
      match_q <= 32'h00000000;
      pre_a_q <= 8'h00;
      pre_b_q <= 8'h00;
      load_q  <= `DTC_LOAD_RST;
    end else begin
      if (wr_at(`DTC_IMR_OFS))
        imr_q <= wdata_i & `DTC_INT_MASK;
      if (wr_at(`DTC_MATCH_A_OFS))
        match_q[15:0] <= wdata_i[15:0];
      if (wr_at(`DTC_MATCH_A_OFS) && !pair_w)
        match_q[31:16] <= wdata_i[31:16];
      if (wr_at(`DTC_MATCH_B_OFS))
        match_q[31:16] <= wdata_i[15:0];
      if (wr_at(`DTC_PRE_A_OFS))
        pre_a_q <= wdata_i[7:0];
      if (wr_at(`DTC_PRE_B_OFS))
        pre_b_q <= wdata_i[7:0];
      if (wr_la_w)
        load_q[15:0] <= wdata_i[15:0];
      if (wr_la_w && !pair_w)
        load_q[31:16] <= wdata_i[31:16];
      if (wr_lb_w)
        load_q[31:16] <= wdata_i[15:0];
    end
  end

  // input samplers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rtc_s_q   <= 1'b0;
      cap_a_s_q <= 1'b0;
      cap_b_s_q <= 1'b0;
    end else begin
      rtc_s_q   <= rtc_clk_i;
      cap_a_s_q <= cap_a_i;
      cap_b_s_q <= cap_b_i;
    end
  end

  assign ev_a_w = pair_w && (mode_a_q == dtc_pkg::DTC_H_CNT
                  || mode_a_q == dtc_pkg::DTC_H_TIME)
                  && ctrl_q[`DTC_CTRL_EN_A]
                  && edge_hit(ctrl_q[`DTC_CTRL_EV_A+:2], cap_a_i,
                              cap_a_s_q);
  assign ev_b_w = pair_w && (mode_b_q == dtc_pkg::DTC_H_CNT
                  || mode_b_q == dtc_pkg::DTC_H_TIME)
                  && ctrl_q[`DTC_CTRL_EN_B]
                  && edge_hit(ctrl_q[`DTC_CTRL_EV_B+:2], cap_b_i,
                              cap_b_s_q);

  // rtc divider: 32768 rising edges make one second
  always_ff @(posedge clk_i) begin
    if (srst_i || cfg_q != dtc_pkg::DTC_JOIN_RTC)
      rtc_div_q <= 15'h0000;
    else if (rtc_clk_i && !rtc_s_q && ctrl_q[`DTC_CTRL_EN_A])
      rtc_div_q <= rtc_div_q + 15'h0001;
  end
  assign rtc_sec_w = cfg_q == dtc_pkg::DTC_JOIN_RTC && rtc_clk_i
                   && !rtc_s_q && rtc_div_q == `DTC_RTC_DIV
                   && ctrl_q[`DTC_CTRL_EN_A];

  // prescalers, only in paired mode
  always_ff @(posedge clk_i) begin
    if (srst_i || !pair_w) begin
      psc_a_q <= 8'h00;
      psc_b_q <= 8'h00;
    end else begin
      if (ctrl_q[`DTC_CTRL_EN_A] && !(ctrl_q[`DTC_CTRL_STL_A] && dbg_halt_i))
        psc_a_q <= (psc_a_q >= pre_a_q) ? 8'h00 : psc_a_q + 8'h01;
      if (ctrl_q[`DTC_CTRL_EN_B] && !(ctrl_q[`DTC_CTRL_STL_B] && dbg_halt_i))
        psc_b_q <= (psc_b_q >= pre_b_q) ? 8'h00 : psc_b_q + 8'h01;
    end
  end

  assign tick_32_w = !pair_w && ctrl_q[`DTC_CTRL_EN_A]
                   && !(ctrl_q[`DTC_CTRL_STL_A] && dbg_halt_i)
                   && cfg_q != dtc_pkg::DTC_JOIN_RTC;
  assign tick_a_w = pair_w && ctrl_q[`DTC_CTRL_EN_A]
                  && !(ctrl_q[`DTC_CTRL_STL_A] && dbg_halt_i)
                  && psc_a_q >= pre_a_q;
  assign tick_b_w = pair_w && ctrl_q[`DTC_CTRL_EN_B]
                  && !(ctrl_q[`DTC_CTRL_STL_B] && dbg_halt_i)
                  && psc_b_q >= pre_b_q;

  // counters: low half first, high half second; joined in 32-bit modes
  always_ff @(posedge clk_i) begin
    if (srst_i)
      cnt_q <= `DTC_LOAD_RST;
    else if (!pair_w) begin
      if (wr_la_w)
        cnt_q <= wdata_i;
      else if (cfg_q == dtc_pkg::DTC_JOIN_RTC) begin
        if (rtc_sec_w)
          cnt_q <= cnt_q + 32'h1;
      end else if (tick_32_w) begin
        if (cnt_q != 32'h0)
          cnt_q <= cnt_q - 32'h1;
        else if (cfg_q == dtc_pkg::DTC_JOIN_PER)
          cnt_q <= load_q;
      end
    end else begin
      if (wr_la_w)
        cnt_q[15:0] <= wdata_i[15:0];
      else if (mode_a_q == dtc_pkg::DTC_H_CNT) begin
        if (ev_a_w)
          cnt_q[15:0] <= cnt_q[15:0] + 16'h1;
      end else if (mode_a_q != dtc_pkg::DTC_H_OS || cnt_q[15:0] != 16'h0) begin
        if (tick_a_w)
          cnt_q[15:0] <= (cnt_q[15:0] == 16'h0) ? load_q[15:0]
                       : cnt_q[15:0] - 16'h1;
      end
      if (wr_lb_w)
        cnt_q[31:16] <= wdata_i[15:0];
      else if (mode_b_q == dtc_pkg::DTC_H_CNT) begin
        if (ev_b_w)
          cnt_q[31:16] <= cnt_q[31:16] + 16'h1;
      end else if (mode_b_q != dtc_pkg::DTC_H_OS || cnt_q[31:16] != 16'h0) begin
        if (tick_b_w)
          cnt_q[31:16] <= (cnt_q[31:16] == 16'h0) ? load_q[31:16]
                        : cnt_q[31:16] - 16'h1;
      end
    end
  end

  // timeout when a tick takes the count from one to zero; capture time uses the counter snapshot
  always_comb begin
    set_w = 32'h0;
    if (!pair_w) begin
      set_w[`DTC_INT_TOA] = tick_32_w && cnt_q == 32'h1;
      set_w[`DTC_INT_RTC] = rtc_sec_w && cnt_q + 32'h1 == match_q;
    end else begin
      set_w[`DTC_INT_TOA] = tick_a_w && cnt_q[15:0] == 16'h1
        && (mode_a_q == dtc_pkg::DTC_H_OS
            || mode_a_q == dtc_pkg::DTC_H_PER);
      set_w[`DTC_INT_TOB] = tick_b_w && cnt_q[31:16] == 16'h1
        && (mode_b_q == dtc_pkg::DTC_H_OS
            || mode_b_q == dtc_pkg::DTC_H_PER);
      set_w[`DTC_INT_CEA] = ev_a_w && ctrl_q[`DTC_CTRL_EN_A];
      set_w[`DTC_INT_CEB] = ev_b_w && ctrl_q[`DTC_CTRL_EN_B];
      set_w[`DTC_INT_CMA] = ev_a_w && mode_a_q == dtc_pkg::DTC_H_CNT
        && cnt_q[15:0] + 16'h1 == match_q[15:0];
      set_w[`DTC_INT_CMB] = ev_b_w && mode_b_q == dtc_pkg::DTC_H_CNT
        && cnt_q[31:16] + 16'h1 == match_q[31:16];
    end
  end

  // sticky raw status; set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i)
      ris_q <= 32'h0;
    else
      ris_q <= (ris_q & ~(wr_at(`DTC_ICR_OFS) ? wdata_i : 32'h0)) | set_w;
  end
  assign irq_o = |(ris_q & imr_q);

  // captured time snapshot for edge-time mode
  logic [15:0] snap_a_q, snap_b_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      snap_a_q <= 16'h0;
      snap_b_q <= 16'h0;
    end else begin
      if (ev_a_w && mode_a_q == dtc_pkg::DTC_H_TIME)
        snap_a_q <= cnt_q[15:0];
      if (ev_b_w && mode_b_q == dtc_pkg::DTC_H_TIME)
        snap_b_q <= cnt_q[31:16];
    end
  end

  // pwm outputs and triggers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_a_o    <= 1'b0;
      cap_b_o    <= 1'b0;
      cap_a_oe_o <= 1'b0;
      cap_b_oe_o <= 1'b0;
      trig_a_o   <= 1'b0;
      trig_b_o   <= 1'b0;
    end else begin
      cap_a_oe_o <= pair_w && mode_a_q == dtc_pkg::DTC_H_PWM;
      cap_b_oe_o <= pair_w && mode_b_q == dtc_pkg::DTC_H_PWM;
      cap_a_o <= (cnt_q[15:0] > match_q[15:0])
                 ^ ctrl_q[`DTC_CTRL_INV_A];
      cap_b_o <= (cnt_q[31:16] > match_q[31:16])
                 ^ ctrl_q[`DTC_CTRL_INV_B];
      trig_a_o <= set_w[`DTC_INT_TOA] && ctrl_q[`DTC_CTRL_TRG_A];
      trig_b_o <= set_w[`DTC_INT_TOB] && ctrl_q[`DTC_CTRL_TRG_B];
    end
  end

  // read port
  always_ff @(posedge clk_i) begin
    if (srst_i)
      rdata_o <= 32'h0;
    else if (rd_i) begin
      case (addr_i)
        `DTC_CFG_OFS:     rdata_o <= {30'h0, cfg_q};
        `DTC_MODE_A_OFS:  rdata_o <= {29'h0, mode_a_q};
        `DTC_MODE_B_OFS:  rdata_o <= {29'h0, mode_b_q};
        `DTC_CTRL_OFS:    rdata_o <= ctrl_q;
        `DTC_IMR_OFS:     rdata_o <= imr_q;
        `DTC_RIS_OFS:     rdata_o <= ris_q;
        `DTC_MIS_OFS:     rdata_o <= ris_q & imr_q;
        `DTC_LOAD_A_OFS:  rdata_o <= pair_w ? {16'h0, load_q[15:0]} : load_q;
        `DTC_LOAD_B_OFS:  rdata_o <= {16'h0, load_q[31:16]};
        `DTC_MATCH_A_OFS: rdata_o <= pair_w ? {16'h0, match_q[15:0]} : match_q;
        `DTC_MATCH_B_OFS: rdata_o <= {16'h0, match_q[31:16]};
        `DTC_PRE_A_OFS:   rdata_o <= {24'h0, pre_a_q};
        `DTC_PRE_B_OFS:   rdata_o <= {24'h0, pre_b_q};
        `DTC_VAL_A_OFS:   rdata_o <= !pair_w ? cnt_q
                          : mode_a_q == dtc_pkg::DTC_H_TIME
                          ? {16'h0, snap_a_q} : {16'h0, cnt_q[15:0]};
        `DTC_VAL_B_OFS:   rdata_o <= mode_b_q == dtc_pkg::DTC_H_TIME
                          ? {16'h0, snap_b_q} : {16'h0, cnt_q[31:16]};
        default:          rdata_o <= 32'h0;
      endcase
    end else
      rdata_o <= 32'h0;
  end

  // config write leaves both halves stopped
  cfg_dis_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_cfg_w |=> !ctrl_q[`DTC_CTRL_EN_A] && !ctrl_q[`DTC_CTRL_EN_B])
    else $error("config write left a half enabled");
  one_shot_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_q == dtc_pkg::DTC_JOIN_OS && cnt_q == 32'h0 && !wr_la_w
    && $stable(cfg_q) |=> cnt_q == 32'h0)
    else $error("one-shot left zero");
  reload_per_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_q == dtc_pkg::DTC_JOIN_PER && tick_32_w && cnt_q == 32'h0
    && !wr_la_w |=> cnt_q == $past(load_q))
    else $error("periodic reload missed");
  timeout_a: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_32_w && cnt_q == 32'h1 && !wr_la_w |=> cnt_q == 32'h0
    && ris_q[`DTC_INT_TOA])
    else $error("timeout not raised at zero");
  load_imm_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_la_w && !pair_w |=> cnt_q == $past(wdata_i))
    else $error("load not immediate");
  pwm_oe_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !pair_w |=> !cap_a_oe_o && !cap_b_oe_o)
    else $error("pwm drive outside paired mode");
  irq_mask_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (set_w & imr_q) != 32'h0 && !(wr_i && addr_i == `DTC_IMR_OFS)
    |=> irq_o)
    else $error("enabled source missed the interrupt");
  stall_hold_a: assert property (@(posedge clk_i)
    disable iff (srst_i) dbg_halt_i && ctrl_q[`DTC_CTRL_STL_A] && !wr_la_w
    && cfg_q != dtc_pkg::DTC_JOIN_RTC
    && !(pair_w && mode_a_q == dtc_pkg::DTC_H_CNT)
    |=> $stable(cnt_q[15:0]))
    else $error("counter ran in debug stall");
  trig_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    trig_a_o |-> $past(ctrl_q[`DTC_CTRL_TRG_A]))
    else $error("trigger while disabled");
  trig_gate_b_a: assert property (@(posedge clk_i)
    disable iff (srst_i) trig_b_o |-> $past(ctrl_q[`DTC_CTRL_TRG_B]))
    else $error("second trigger while disabled");
  en_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    pair_w && !ctrl_q[`DTC_CTRL_EN_A] && !wr_la_w
    |=> $stable(cnt_q[15:0]))
    else $error("disabled half counted");
  mode_ign_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_i && addr_i == `DTC_MODE_A_OFS && wdata_i[2:0] > 3'h4
    |=> $stable(mode_a_q))
    else $error("bad half mode accepted");
endmodule : dtc_top

//--- core/dtc_params.svh
// register offsets, field positions and reset values of the dual timer
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_CFG_OFS     8'h00
`define DTC_MODE_A_OFS  8'h04
`define DTC_MODE_B_OFS  8'h08
`define DTC_CTRL_OFS    8'h0C
`define DTC_IMR_OFS     8'h18
`define DTC_RIS_OFS     8'h1C
`define DTC_MIS_OFS     8'h20
`define DTC_ICR_OFS     8'h24
`define DTC_LOAD_A_OFS  8'h28
`define DTC_LOAD_B_OFS  8'h2C
`define DTC_MATCH_A_OFS 8'h30
`define DTC_MATCH_B_OFS 8'h34
`define DTC_PRE_A_OFS   8'h38
`define DTC_PRE_B_OFS   8'h3C
`define DTC_VAL_A_OFS   8'h48
`define DTC_VAL_B_OFS   8'h4C
`define DTC_CTRL_EN_A   0
`define DTC_CTRL_STL_A  1
`define DTC_CTRL_TRG_A  2
`define DTC_CTRL_EV_A   3
`define DTC_CTRL_INV_A  5
`define DTC_CTRL_EN_B   8
`define DTC_CTRL_STL_B  9
`define DTC_CTRL_TRG_B  10
`define DTC_CTRL_EV_B   11
`define DTC_CTRL_INV_B  13
`define DTC_CTRL_MASK   32'h00003F3F
`define DTC_INT_TOA     0
`define DTC_INT_CMA     1
`define DTC_INT_CEA     2
`define DTC_INT_RTC     3
`define DTC_INT_TOB     8
`define DTC_INT_CMB     9
`define DTC_INT_CEB     10
`define DTC_INT_MASK    32'h0000070F
`define DTC_LOAD_RST    32'hFFFFFFFF
`define DTC_RTC_DIV     15'h7FFF
`endif

//--- core/dtc_pkg.sv
// types of the dual timer
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_JOIN_OS, DTC_JOIN_PER, DTC_JOIN_RTC, DTC_PAIR
  } dtc_cfg_e;
  typedef enum logic [2:0] {
    DTC_H_OS, DTC_H_PER, DTC_H_CNT, DTC_H_TIME, DTC_H_PWM
  } dtc_half_e;
endpackage : dtc_pkg

//--- tb/tb.sv
// self-checking bench of the dual timer/counter
`timescale 1ns/100ps
`include "dtc_params.svh"
module tb;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } dtc_row_s;
  logic        clk_i      = 1'h0;
  logic        srst_i     = 1'h1;
  logic [7:0]  addr_i     = 8'h00;
  logic [31:0] wdata_i    = 32'h0;
  logic        wr_i       = 1'h0;
  logic        rd_i       = 1'h0;
  logic        dbg_halt_i = 1'h0;
  logic        rtc_clk_i  = 1'h0;
  logic        cap_a_i    = 1'h0;
  logic        cap_b_i    = 1'h0;
  logic        rtc_run    = 1'h0;
  logic [31:0] rdata_o;
  logic        cap_a_o, cap_a_oe_o, cap_b_o, cap_b_oe_o;
  logic        trig_a_o, trig_b_o, irq_o;
  logic [31:0] v, v1;
  int          mismatches = 0;
  int          n_compared = 0;
  int          n;
  dtc_row_s    rows [11];

  dtc_top uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .dbg_halt_i(dbg_halt_i), .rtc_clk_i(rtc_clk_i), .cap_a_i(cap_a_i),
    .cap_a_o(cap_a_o), .cap_a_oe_o(cap_a_oe_o), .cap_b_i(cap_b_i),
    .cap_b_o(cap_b_o), .cap_b_oe_o(cap_b_oe_o), .trig_a_o(trig_a_o),
    .trig_b_o(trig_b_o), .irq_o(irq_o));

  always #10 clk_i = ~clk_i;
  // fast stand-in for the slow clock, still only sampled edges
  always @(posedge clk_i) if (rtc_run) rtc_clk_i <= ~rtc_clk_i;

  task chk(input string nm, input logic [31:0] seen,
           input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task end_of_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clk_i);
    wr_i    <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clk_i);
    rd_i   <= 1'h0;
    @(negedge clk_i);
    q = rdata_o;
  endtask : rd

  task do_reset;
    @(posedge clk_i);
    srst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'h0;
    @(negedge clk_i);
  endtask : do_reset

  // cycles until the next trigger pulse, bounded
  task automatic tpulse(output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (trig_a_o !== 1'h1 && k < 1000);
    if (k >= 1000) begin
      chk("trig_wait", 32'h0, 32'h1);
      end_of_test();
    end
  endtask : tpulse

  task automatic hi_count(input int cyc, input bit pwm, output int k);
    k = 0;
    repeat (3) @(negedge clk_i);
    repeat (cyc) begin
      @(negedge clk_i);
      k += pwm ? int'(cap_b_o === 1'h1) : int'(trig_a_o === 1'h1);
    end
  endtask : hi_count

  task pulse_a(input int k);
    repeat (k) begin
      @(posedge clk_i);
      cap_a_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      cap_a_i <= 1'h0;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : pulse_a

  initial begin
    rows = '{'{`DTC_CFG_OFS, 32'h1, 32'h1}, '{`DTC_CFG_OFS, 32'h3, 32'h3},
      '{`DTC_MODE_A_OFS, 32'h4, 32'h4}, '{`DTC_MODE_A_OFS, 32'h5, 32'h4},
      '{`DTC_MODE_B_OFS, 32'h1, 32'h1},
      '{`DTC_IMR_OFS, 32'hFFFFFFFF, `DTC_INT_MASK},
      '{`DTC_RIS_OFS, 32'hFFFFFFFF, 32'h0},
      '{`DTC_MIS_OFS, 32'hFFFFFFFF, 32'h0}, '{8'h10, 32'hFFFFFFFF, 32'h0},
      '{`DTC_IMR_OFS, 32'h0, 32'h0},
      '{`DTC_CTRL_OFS, 32'hFFFFFFFF, `DTC_CTRL_MASK}};
    do_reset();
    chk("rst_out", {25'h0, irq_o, trig_a_o, trig_b_o, cap_a_o, cap_b_o,
                    cap_a_oe_o, cap_b_oe_o}, 32'h0);
    rd(`DTC_CFG_OFS, v);
    chk("rst_cfg", v, 32'(dtc_pkg::DTC_PAIR));
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("row", v, rows[i].e);
    end
    wr(`DTC_CFG_OFS, 32'h3);
    rd(`DTC_CTRL_OFS, v);
    chk("cfg_disables", v, 32'h00003E3E);
    // paired periodic half with prescale: 4 counts of 2 cycles
    wr(`DTC_MODE_A_OFS, 32'h1);
    wr(`DTC_LOAD_A_OFS, 32'h3);
    wr(`DTC_PRE_A_OFS, 32'h1);
    wr(`DTC_CTRL_OFS, 32'h5);
    tpulse(n);
    tpulse(n);
    chk("pre_period", 32'(n), 32'h8);
    // joined periodic ignores the prescaler
    wr(`DTC_CFG_OFS, 32'h1);
    wr(`DTC_LOAD_A_OFS, 32'h5);
    wr(`DTC_CTRL_OFS, 32'h5);
    tpulse(n);
    tpulse(n);
    chk("per_period", 32'(n), 32'h6);
    wr(`DTC_LOAD_A_OFS, 32'h2);
    tpulse(n);
    tpulse(n);
    chk("new_load", 32'(n), 32'h3);
    @(posedge clk_i);
    dbg_halt_i <= 1'h1;
    wr(`DTC_CTRL_OFS, 32'h7);
    hi_count(40, 1'b0, n);
    chk("stalled", 32'(n), 32'h0);
    wr(`DTC_CTRL_OFS, 32'h5);
    tpulse(n);
    tpulse(n);
    chk("no_stall", 32'(n), 32'h3);
    @(posedge clk_i);
    dbg_halt_i <= 1'h0;
    wr(`DTC_CTRL_OFS, 32'h1);
    hi_count(40, 1'b0, n);
    chk("trig_off", 32'(n), 32'h0);
    rd(`DTC_RIS_OFS, v);
    chk("ris_to", v & 32'h1, 32'h1);
    chk("irq_masked", 32'(irq_o), 32'h0);
    wr(`DTC_IMR_OFS, 32'h1);
    @(negedge clk_i);
    chk("irq_on", 32'(irq_o), 32'h1);
    rd(`DTC_MIS_OFS, v);
    chk("mis", v, 32'h1);
    wr(`DTC_CTRL_OFS, 32'h0);
    wr(`DTC_ICR_OFS, 32'hFFFFFFFF);
    rd(`DTC_RIS_OFS, v);
    chk("ris_clr", v, 32'h0);
    chk("irq_off", 32'(irq_o), 32'h0);
    // joined one-shot borrows across the halves
    wr(`DTC_CFG_OFS, 32'h0);
    wr(`DTC_LOAD_A_OFS, 32'h00010002);
    wr(`DTC_CTRL_OFS, 32'h5);
    repeat (10) @(posedge clk_i);
    rd(`DTC_VAL_A_OFS, v);
    chk("val32", v & 32'hFFFFFF00, 32'h0000FF00);
    wr(`DTC_LOAD_A_OFS, 32'h3);
    tpulse(n);
    hi_count(40, 1'b0, n);
    chk("os_stop", 32'(n), 32'h0);
    rd(`DTC_VAL_A_OFS, v);
    chk("os_zero", v, 32'h0);
    wr(`DTC_CFG_OFS, 32'h3);
    wr(`DTC_MODE_A_OFS, 32'h2);
    for (int e = 0; e < 3; e++) begin
      wr(`DTC_CTRL_OFS, 32'h1 | (32'(e) << 3));
      rd(`DTC_VAL_A_OFS, v);
      pulse_a(3);
      rd(`DTC_VAL_A_OFS, v1);
      chk("edges", (v1 - v) & 32'hFFFF, (e == 2) ? 32'h6 : 32'h3);
    end
    wr(`DTC_CTRL_OFS, 32'h0);
    rd(`DTC_VAL_A_OFS, v);
    pulse_a(1);
    rd(`DTC_VAL_A_OFS, v1);
    chk("cnt_off", v1, v);
    wr(`DTC_CTRL_OFS, 32'h1);
    rd(`DTC_VAL_A_OFS, v);
    wr(`DTC_MATCH_A_OFS, (v + 32'h2) & 32'hFFFF);
    wr(`DTC_ICR_OFS, 32'hFFFFFFFF);
    pulse_a(1);
    rd(`DTC_RIS_OFS, v1);
    chk("cap_ev", v1 & 32'h6, 32'h4);
    pulse_a(1);
    rd(`DTC_RIS_OFS, v1);
    chk("cap_match", v1 & 32'h6, 32'h6);
    // edge-time half holds a snapshot until the next edge
    wr(`DTC_MODE_A_OFS, 32'h3);
    wr(`DTC_CTRL_OFS, 32'h1);
    pulse_a(1);
    rd(`DTC_VAL_A_OFS, v);
    repeat (10) @(posedge clk_i);
    rd(`DTC_VAL_A_OFS, v1);
    chk("snap_hold", v1, v);
    pulse_a(1);
    rd(`DTC_VAL_A_OFS, v1);
    chk("snap_new", 32'(v1 === v), 32'h0);
    wr(`DTC_MODE_B_OFS, 32'h1);
    wr(`DTC_LOAD_B_OFS, 32'h9);
    wr(`DTC_CTRL_OFS, 32'h0500);
    n = 0;
    repeat (20) begin
      @(negedge clk_i);
      n += int'(trig_b_o === 1'h1);
    end
    chk("trig_b", 32'(n), 32'h2);
    wr(`DTC_MODE_B_OFS, 32'h4);
    wr(`DTC_LOAD_B_OFS, 32'h9);
    wr(`DTC_MATCH_B_OFS, 32'h2);
    wr(`DTC_CTRL_OFS, 32'h0100);
    hi_count(20, 1'b1, n);
    chk("pwm_oe", {30'h0, cap_a_oe_o, cap_b_oe_o}, 32'h1);
    chk("pwm_duty", 32'(n), 32'hE);
    wr(`DTC_CTRL_OFS, 32'h2100);
    hi_count(20, 1'b1, n);
    chk("pwm_inv", 32'(n), 32'h6);
    wr(`DTC_CFG_OFS, 32'h1);
    repeat (2) @(negedge clk_i);
    chk("no_pwm32", 32'(cap_b_oe_o), 32'h0);
    wr(`DTC_CFG_OFS, 32'h2);
    rd(`DTC_VAL_A_OFS, v);
    wr(`DTC_MATCH_A_OFS, v + 32'h1);
    wr(`DTC_ICR_OFS, 32'hFFFFFFFF);
    wr(`DTC_IMR_OFS, 32'h8);
    wr(`DTC_CTRL_OFS, 32'h1);
    rtc_run <= 1'h1;
    repeat (60000) @(negedge clk_i);
    chk("rtc_early", 32'(irq_o), 32'h0);
    n = 0;
    while (irq_o !== 1'h1 && n < 10000) begin
      @(negedge clk_i);
      n++;
    end
    chk("rtc_match", 32'(n < 10000), 32'h1);
    rtc_run <= 1'h0;
    rd(`DTC_VAL_A_OFS, v1);
    chk("rtc_sec", v1, v + 32'h1);
    do_reset();
    rd(`DTC_CFG_OFS, v);
    chk("rerst_cfg", v, 32'(dtc_pkg::DTC_PAIR));
    rd(`DTC_CTRL_OFS, v);
    chk("rerst_ctrl", v, 32'h0);
    end_of_test();
  end
endmodule : tb
